//--- design/spdc_chan_cnt.sv
// Purpose: one channel slot sampler and gated pulse counter
// Assumes: i_sample strikes once per transmitter clock at the channel slot
// Notes: a low line at the sample point means a data pulse is present
`timescale 1ns/10ps
module spdc_chan_cnt (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_sample,
    input wire logic i_level,
    input wire logic i_gate_end,
    output spdc_pkg::spdc_chan_s o_chan
);
    logic slot_r;
    logic [spdc_pkg::CNT_W-1:0] cnt_r;
    logic [spdc_pkg::CNT_W-1:0] hold_r;
    wire logic inc = i_sample & ~i_level & ~slot_r;
    wire logic [spdc_pkg::CNT_W-1:0] cnt_nxt = cnt_r + spdc_pkg::CNT_W'(inc);

    // ==========================================
    // slot flip-flop and counter
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slot_r <= 1'b0;
            cnt_r <= spdc_pkg::CNT_RST;
            hold_r <= spdc_pkg::CNT_RST;
        end else if (i_ce) begin
            if (i_sample) begin
                slot_r <= ~i_level;
            end
            if (i_gate_end) begin
                // a pulse landing on the gate edge belongs to the closing gate
                hold_r <= cnt_nxt;
                cnt_r <= spdc_pkg::CNT_RST;
            end else begin
                cnt_r <= cnt_nxt;
            end
        end
    end

    assign o_chan = '{slot: slot_r, count: hold_r};

    a_gate_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
        i_gate_end |=> (cnt_r == spdc_pkg::CNT_RST) && (hold_r == $past(cnt_nxt)))
        else $error("counter not cleared or held at gate end");
endmodule

//--- design/spdc_pkg.sv
// Purpose: shared constants and types of the sync pulse demultiplexing counter
// Assumes: one 10 MHz reference clock, inputs synchronous to it
// Notes: all timing counts are derived here from times in ns
package spdc_pkg;
    // ==========================================
    // clock and timing
    localparam int REF_NS = 100;
    localparam int ONESHOT_NS = 400;
    // least time: round up to whole cycles
    localparam int ONESHOT_CYC = (ONESHOT_NS + REF_NS - 1) / REF_NS;
    localparam int TMR_W = 4;
    localparam logic [TMR_W-1:0] ONESHOT_LD = TMR_W'(ONESHOT_CYC);
    localparam logic [TMR_W-1:0] TMR_LAST = 4'h1;
    localparam logic [TMR_W-1:0] TMR_RST = 4'h0;

    // ==========================================
    // widths
    localparam int NCH = 3;
    localparam int CNT_W = 16;
    localparam int PER_W = 16;
    localparam int DIV_STAGES = 14;
    localparam int GATE_W = DIV_STAGES + 1;
    localparam int SEL_W = 4;
    localparam logic [SEL_W-1:0] SEL_MIN = 4'h1;
    localparam logic [SEL_W-1:0] SEL_MAX = 4'he;
    localparam logic [1:0] LOCK_SYNCS = 2'h2;

    // ==========================================
    // reset values
    localparam logic REC_CLK_IDLE = 1'b1;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [PER_W-1:0] PER_RST = 16'h0000;
    localparam logic [GATE_W-1:0] GATE_RST = 15'h0000;

    typedef struct packed {
        logic slot;
        logic [CNT_W-1:0] count;
    } spdc_chan_s;
endpackage

//--- design/spdc_top.sv
// Purpose: split a wire-ORed sync/data pulse stream, rebuild the clock, count per channel
// Assumes: line idles high, pulses pull it low; transmitter clock far below 10 MHz
// Notes: multiphase clock is a digital phase counter locked to each sync pulse
`timescale 1ns/10ps
module spdc_top (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_mux_line,
    input wire logic [spdc_pkg::SEL_W-1:0] i_gate_sel,
    output logic o_rec_clk_n,
    output logic o_locked,
    output logic [spdc_pkg::PER_W-1:0] o_period,
    output logic o_gate_done,
    output logic [spdc_pkg::GATE_W-1:0] o_gate_periods,
    output spdc_pkg::spdc_chan_s [spdc_pkg::NCH-1:0] o_chan
);
    typedef enum logic [1:0] {ST_IDLE, ST_TIME, ST_CLR} spdc_state_e;

    spdc_state_e state_r;
    spdc_state_e state_nxt;
    logic [spdc_pkg::TMR_W-1:0] timer_r;
    logic [spdc_pkg::TMR_W-1:0] timer_nxt;
    logic line_d_r;
    logic cap_r;
    logic rec_clk_n_r;
    logic rec_clk_n_nxt;
    logic sync_ev_r;
    logic [spdc_pkg::PER_W-1:0] pos_r;
    logic [spdc_pkg::PER_W-1:0] period_r;
    logic [1:0] syncs_r;
    logic [spdc_pkg::GATE_W-1:0] div_r;
    logic gate_end_r;
    logic [spdc_pkg::GATE_W-1:0] gate_periods_r;
    logic [spdc_pkg::NCH-1:0] strobe_r;

    // ==========================================
    // pulse width discriminator
    wire logic fall = line_d_r & ~i_mux_line;
    wire logic tmr_end = (state_r == ST_TIME) && (timer_r == spdc_pkg::TMR_LAST);
    // short pulse has already returned high when the timing pulse ends
    wire logic is_sync = tmr_end & i_mux_line;

    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        rec_clk_n_nxt = rec_clk_n_r;
        case (state_r)
            ST_IDLE: begin
                if (fall) begin
                    state_nxt = ST_TIME;
                    timer_nxt = spdc_pkg::ONESHOT_LD;
                end
            end
            ST_TIME: begin
                // not retriggerable: edges inside the timing pulse are ignored
                if (timer_r == spdc_pkg::TMR_LAST) begin
                    rec_clk_n_nxt = ~i_mux_line;
                    state_nxt = i_mux_line ? ST_CLR : ST_IDLE;
                end else begin
                    timer_nxt = timer_r - spdc_pkg::TMR_LAST;
                end
            end
            ST_CLR: begin
                // one reference cycle stands in for the two gate delays
                rec_clk_n_nxt = spdc_pkg::REC_CLK_IDLE;
                state_nxt = ST_IDLE;
                if (fall) begin
                    state_nxt = ST_TIME;
                    timer_nxt = spdc_pkg::ONESHOT_LD;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                rec_clk_n_nxt = spdc_pkg::REC_CLK_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_IDLE;
            timer_r <= spdc_pkg::TMR_RST;
            line_d_r <= spdc_pkg::LINE_IDLE;
            cap_r <= 1'b0;
            rec_clk_n_r <= spdc_pkg::REC_CLK_IDLE;
            sync_ev_r <= 1'b0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            line_d_r <= i_mux_line;
            if (tmr_end) begin
                cap_r <= i_mux_line;
            end else if (state_r == ST_CLR) begin
                cap_r <= 1'b0;
            end
            rec_clk_n_r <= rec_clk_n_nxt;
            sync_ev_r <= is_sync;
        end
    end

    // ==========================================
    // phase counter locked to the rebuilt clock
    function automatic logic [spdc_pkg::PER_W-1:0] slot_point(input logic [spdc_pkg::PER_W-1:0] per,
                                                            input int unsigned k);
        logic [spdc_pkg::PER_W-1:0] q;
        q = per >> 2;
        // centre of quarter k, clear of the 150 ns output delay at its start
        slot_point = spdc_pkg::PER_W'(q * k) + (q >> 1);
    endfunction

    wire logic pos_sat = &pos_r;
    wire logic locked = (syncs_r == spdc_pkg::LOCK_SYNCS);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pos_r <= spdc_pkg::PER_RST;
            period_r <= spdc_pkg::PER_RST;
            syncs_r <= 2'h0;
        end else if (i_ce) begin
            if (sync_ev_r) begin
                pos_r <= spdc_pkg::PER_RST;
                period_r <= pos_r + 16'h0001;
                if (!locked) begin
                    syncs_r <= syncs_r + 2'h1;
                end
            end else if (!pos_sat) begin
                pos_r <= pos_r + 16'h0001;
            end
        end
    end

    // ==========================================
    // channel slots; phase 0 carries the sync pulse
    genvar g;
    generate
        for (g = 0; g < spdc_pkg::NCH; g++) begin : g_chan
            wire logic hit = locked && (pos_r == slot_point(period_r, g + 1));
            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    strobe_r[g] <= 1'b0;
                end else if (i_ce) begin
                    strobe_r[g] <= hit & ~sync_ev_r;
                end
            end
            spdc_chan_cnt u_chan (
                .i_ref_clk(i_ref_clk),
                .i_rst_n(i_rst_n),
                .i_ce(i_ce),
                .i_sample(strobe_r[g]),
                .i_level(i_mux_line),
                .i_gate_end(gate_end_r),
                .o_chan(o_chan[g])
            );
        end
    endgenerate

    // ==========================================
    // gate divider counting rebuilt clock periods
    // taps 1..14 give 2 to 16384 periods; choose so the gate spans whole mains cycles
    wire logic [spdc_pkg::SEL_W-1:0] sel_lo = (i_gate_sel < spdc_pkg::SEL_MIN) ? spdc_pkg::SEL_MIN : i_gate_sel;
    wire logic [spdc_pkg::SEL_W-1:0] sel = (sel_lo > spdc_pkg::SEL_MAX) ? spdc_pkg::SEL_MAX : sel_lo;
    wire logic [spdc_pkg::GATE_W-1:0] gate_len = spdc_pkg::GATE_W'(1) << sel;
    wire logic [spdc_pkg::GATE_W-1:0] div_inc = div_r + spdc_pkg::GATE_W'(1);
    wire logic div_wrap = sync_ev_r && (div_inc >= gate_len);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r <= spdc_pkg::GATE_RST;
            gate_end_r <= 1'b0;
            gate_periods_r <= spdc_pkg::GATE_RST;
        end else if (i_ce) begin
            gate_end_r <= div_wrap;
            if (div_wrap) begin
                div_r <= spdc_pkg::GATE_RST;
                gate_periods_r <= div_inc;
            end else if (sync_ev_r) begin
                div_r <= div_inc;
            end
        end
    end

    // ==========================================
    // registered outputs
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rec_clk_n <= spdc_pkg::REC_CLK_IDLE;
            o_locked <= 1'b0;
            o_period <= spdc_pkg::PER_RST;
            o_gate_done <= 1'b0;
            o_gate_periods <= spdc_pkg::GATE_RST;
        end else if (i_ce) begin
            o_rec_clk_n <= rec_clk_n_r;
            o_locked <= locked;
            o_period <= period_r;
            o_gate_done <= gate_end_r;
            o_gate_periods <= gate_periods_r;
        end
    end

    // ==========================================
    // checks
    sequence s_short_pulse;
        (state_r == ST_TIME && timer_r == spdc_pkg::TMR_LAST && i_mux_line);
    endsequence
    sequence s_long_pulse;
        (state_r == ST_TIME && timer_r == spdc_pkg::TMR_LAST && !i_mux_line);
    endsequence

    a_oneshot_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
        (state_r == ST_IDLE && fall) |=> (state_r == ST_TIME && timer_r == spdc_pkg::ONESHOT_LD))
        else $error("timing pulse not started on falling edge");
    a_capture_level: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
        tmr_end |=> cap_r == $past(i_mux_line))
        else $error("line level not captured at end of timing pulse");
    a_width_class: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
        (state_r == ST_IDLE && fall) ##1 (!i_mux_line && !fall)[*4] |=> !sync_ev_r)
        else $error("long pulse taken as sync");
    a_sync_clock: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
        s_short_pulse |=> !rec_clk_n_r ##1 !o_rec_clk_n)
        else $error("sync pulse gave no rebuilt clock pulse");
    a_clock_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
        s_short_pulse |=> !rec_clk_n_r ##1 (rec_clk_n_r && !cap_r))
        else $error("rebuilt clock not released after one cycle");
    a_data_noclk: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
        s_long_pulse |=> rec_clk_n_r [*2])
        else $error("data pulse produced a rebuilt clock pulse");
    a_phase_lock: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
        (sync_ev_r && !pos_sat) |=> (pos_r == spdc_pkg::PER_RST) && (period_r == $past(pos_r) + 16'h0001))
        else $error("phase counter not realigned on sync");
    a_slot_sample: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
        strobe_r[0] |=> o_chan[0].slot == !$past(i_mux_line))
        else $error("channel slot not sampled at its phase");
    a_gate_length: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
        (div_wrap && $stable(i_gate_sel)) |=> ##1 (o_gate_done && o_gate_periods == $past(gate_len, 2)))
        else $error("gate did not last the selected number of periods");
endmodule

//--- tb/spdc_tx_model.sv
// Purpose: far-side model, wire-ORed converters with a sync pulse on every period
// Assumes: line idles high through its pull-up and a pulse pulls it low
// Notes: i_long_sync stretches the sync pulse so that it reads as a data pulse
`timescale 1ns/10ps
module spdc_tx_model #(
    parameter int PER = 80
) (
    input wire logic i_ref_clk,
    input wire logic i_run,
    input wire logic [2:0] i_en,
    input wire logic i_long_sync,
    output logic o_line = 1'b1
);
    int ph = 0;
    int fr = 0;
    logic low_w;
    // ==========================================
    // pulse slots
    always_comb begin
        low_w = ph < (i_long_sync ? 6 : 2);
        for (int g = 0; g < 3; g++) begin
            // one channel at most every second period, slot one cycle short of a quarter
            if (i_en[g] && (fr % ((g == 2) ? 4 : 2)) == ((g == 1) ? 1 : 0)
                && ph >= (PER / 4) * (g + 1) && ph < (PER / 4) * (g + 2) - 1) begin
                low_w = 1'b1;
            end
        end
    end
    always @(posedge i_ref_clk) begin
        ph <= (!i_run || ph == PER - 1) ? 0 : ph + 1;
        fr <= !i_run ? 0 : fr + ((ph == PER - 1) ? 1 : 0);
        // level decided before the edge, shown just after the rising edge
        o_line <= #1 !(i_run && low_w);
    end
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench of the pulse stream demultiplexing counter
// Assumes: model period 80 ref cycles, channels 0 and 2 sending, channel 1 silent
// Notes: counts carry one count of slack, gate phase against data phase is free
`timescale 1ns/10ps
module tb_top;
    localparam int PER = 80;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_ce = 1'b1;
    logic run = 1'b0;
    logic long_sync = 1'b0;
    logic [spdc_pkg::SEL_W-1:0] gate_sel = 4'h3;
    logic line;
    logic rec_clk_n;
    logic locked;
    logic gate_done;
    logic [spdc_pkg::PER_W-1:0] period;
    logic [spdc_pkg::GATE_W-1:0] gate_periods;
    spdc_pkg::spdc_chan_s [spdc_pkg::NCH-1:0] chan;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;

    always #50 i_ref_clk = ~i_ref_clk;

    spdc_tx_model #(.PER(PER)) tx (.i_ref_clk(i_ref_clk), .i_run(run), .i_en(3'h5),
        .i_long_sync(long_sync), .o_line(line));
    spdc_top dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_mux_line(line),
        .i_gate_sel(gate_sel), .o_rec_clk_n(rec_clk_n), .o_locked(locked), .o_period(period),
        .o_gate_done(gate_done), .o_gate_periods(gate_periods), .o_chan(chan));

    // ==========================================
    // helpers
    function automatic logic miss(input logic ok);
        n_tests++;
        return ok !== 1'b1;
    endfunction
    task automatic bad(input string msg);
        fails++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask
    task automatic tick();
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_done(output int n);
        n = 0;
        do begin
            tick();
            n++;
        end while (gate_done !== 1'b1 && n < 20000);
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        if (miss(rec_clk_n === 1'b1 && locked === 1'b0 && gate_done === 1'b0)) bad("reset flags");
        if (miss(period === '0 && gate_periods === '0 && chan === '0)) bad("reset values");
    endtask
    task automatic t_recon();
        int lows;
        int runs;
        logic s0_hi;
        logic s0_lo;
        logic s1_hi;
        logic prev;
        lows = 0;
        runs = 0;
        prev = 1'b1;
        s0_hi = 1'b0;
        s0_lo = 1'b0;
        s1_hi = 1'b0;
        for (int i = 0; i < 8 * PER && locked !== 1'b1; i++) tick();
        if (miss(locked === 1'b1)) bad("no lock");
        repeat (2 * PER) tick();
        for (int i = 0; i < 4 * PER; i++) begin
            tick();
            lows += (rec_clk_n === 1'b0) ? 1 : 0;
            runs += (rec_clk_n === 1'b0 && prev === 1'b0) ? 1 : 0;
            prev = rec_clk_n;
            s0_hi |= chan[0].slot === 1'b1;
            s0_lo |= chan[0].slot === 1'b0;
            s1_hi |= chan[1].slot !== 1'b0;
        end
        if (miss(lows == 4)) bad("rebuilt clock pulses per period");
        if (miss(runs == 0)) bad("rebuilt clock low too long");
        if (miss(period === 16'(PER))) bad("measured period");
        if (miss(s0_hi && s0_lo && !s1_hi)) bad("slot sampling");
    endtask
    task automatic t_gate(input logic [3:0] sel, input int k);
        int n;
        logic [spdc_pkg::CNT_W-1:0] c0;
        gate_sel = sel;
        wait_done(n);
        wait_done(n);
        wait_done(n);
        c0 = chan[0].count;
        if (miss(n == (1 << k) * PER)) bad("gate spacing");
        if (miss(gate_periods === 15'(1 << k))) bad("gate periods");
        if (miss(c0 + 1 >= (1 << k) / 2 && c0 <= (1 << k) / 2 + 1)) bad("channel 0 count");
        if (miss(chan[1].count === '0)) bad("silent channel count");
        if (miss(chan[2].count + 1 >= (1 << k) / 4 && chan[2].count <= (1 << k) / 4 + 1)) bad("ch2 count");
        repeat (PER) tick();
        if (miss(chan[0].count === c0)) bad("count not held");
    endtask
    task automatic t_freeze();
        spdc_pkg::spdc_chan_s [spdc_pkg::NCH-1:0] c;
        logic [spdc_pkg::PER_W-1:0] p;
        logic r;
        int moved;
        c = chan;
        p = period;
        r = rec_clk_n;
        moved = 0;
        i_ce = 1'b0;
        for (int i = 0; i < 3 * PER; i++) begin
            tick();
            moved += (chan !== c || period !== p || rec_clk_n !== r || locked !== 1'b1) ? 1 : 0;
        end
        i_ce = 1'b1;
        if (miss(moved == 0)) bad("outputs moved with clock enable low");
    endtask
    task automatic t_long();
        int lows;
        lows = 0;
        long_sync = 1'b1;
        repeat (2 * PER) tick();
        for (int i = 0; i < 4 * PER; i++) begin
            tick();
            lows += (rec_clk_n !== 1'b1) ? 1 : 0;
        end
        if (miss(lows == 0)) bad("long pulse rebuilt a clock");
    endtask

    // ==========================================
    // sequence and timeout
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad("timeout");
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge i_ref_clk);
        t_reset();
        #1;
        i_rst_n = 1'b1;
        run = 1'b1;
        t_recon();
        t_gate(4'h3, 3);
        t_gate(4'h1, 1);
        t_gate(4'h0, 1);
        t_gate(4'h2, 2);
        t_freeze();
        t_long();
        give_verdict();
    end
endmodule
